/* File: src/ifb_defs.vh */
// Constants of the interrupt flag and enable bank
`ifndef IFB_DEFS_VH
`define IFB_DEFS_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IFB_IDX_FLAGS4 8'h90
`define IFB_IDX_FLAGS5 8'h92
`define IFB_IDX_FLAGS6 8'h94
`define IFB_IDX_FLAGS7 8'h96
`define IFB_IDX_EN0 8'h98
`define IFB_IDX_EN1 8'h9a
`define IFB_IDX_EN2 8'h9c
`define IFB_IDX_EN3 8'h9e
`define IFB_IDX_STAT 8'hb0
`define IFB_IDX_IRQEN 8'hb1
`define IFB_IDX_IRQCLR 8'hb2
`define IFB_IDX_PRIO_BASE 8'hc0

// ----------------------------------------
// Implemented bit masks
// ----------------------------------------
`define IFB_MASK_FLAGS4 16'h010f
`define IFB_MASK_FLAGS5 16'hc070
`define IFB_MASK_FLAGS6 16'h440f
`define IFB_MASK_FLAGS7 16'h0020
`define IFB_MASK_EN0 16'hff9f
`define IFB_MASK_EN1 16'he05f
`define IFB_MASK_EN2 16'h9803
`define IFB_MASK_EN3 16'hcc66

// ----------------------------------------
// Reset values and widths
// ----------------------------------------
`define IFB_RST_WORD 16'h0000
`define IFB_RST_PRIO 3'h4
`define IFB_PRIO_W 3
`define IFB_NSRC 64
`define IFB_STAT_W 2
`define IFB_STAT_FLAG 0
`define IFB_STAT_PEND 1

`endif

/* File: src/ifb_word.v */
// One 16-bit flag-or-enable word with hardware set and software write
`timescale 1ns/1ps
`default_nettype none
`include "ifb_defs.vh"

module ifb_word #(
    parameter [15:0] MASK = 16'hffff
) (
    input wire hclk,
    input wire hresetn,
    input wire wr_en,
    input wire [15:0] wr_data,
    input wire [15:0] hw_set,
    output reg [15:0] word_r
);

// ----------------------------------------
// Storage
// ----------------------------------------
// Software write lands directly; a hardware set in the same cycle wins
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        word_r <= `IFB_RST_WORD;
    end else begin
        word_r <= ((wr_en ? wr_data : word_r) | hw_set) & MASK;
    end
end

endmodule // ifb_word
`default_nettype wire

/* File: src/ifb_prio.v */
// Bank of 3-bit priority levels, one per source
`timescale 1ns/1ps
`default_nettype none
`include "ifb_defs.vh"

module ifb_prio (
    input wire hclk,
    input wire hresetn,
    input wire wr_en,
    input wire [5:0] wr_sel,
    input wire [2:0] wr_data,
    input wire [5:0] rd_sel,
    output wire [2:0] rd_data,
    output wire [191:0] prio_flat
);

reg [2:0] prio_mem [0:63];
genvar g;

// ----------------------------------------
// Levels, default 4 after reset
// ----------------------------------------
generate
    for (g = 0; g < 64; g = g + 1) begin : g_lvl
        always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                prio_mem[g] <= `IFB_RST_PRIO;
            end else if (wr_en && wr_sel == g) begin
                prio_mem[g] <= wr_data;
            end
        end
        assign prio_flat[g*3 +: 3] = prio_mem[g];
    end
endgenerate

assign rd_data = prio_mem[rd_sel];

endmodule // ifb_prio
`default_nettype wire

/* File: src/ifb_bank.v */
// Interrupt request flag words 4..7 and enable words 0..3 behind AHB-Lite
// Contract
// - Flag word 4 holds voltage-detect at bit 8, checksum at 3, serial errors at 2 and 1, capcomp2 at 0.
// - Flag word 5 holds capcomp4 and 3 at bits 15 and 14, USB at 6, two-wire collisions at 5 and 4, reset 0.
// - Flag word 6 holds timestamp at 14, oscillator self-tune at 10, logic cells at 3..0, reset 0.
// - Flag word 7 holds only the test-port flag at bit 5, reset 0, one meaning it occurred.
// - Enable word 0 holds bits 15..8, 7 and 4..0, read/write, reset 0.
// - Enable word 1 holds bits 15..13, 6 and 4..0, read/write, reset 0.
// - Enable word 2 holds bits 15, 12, 11, 1 and 0, read/write, reset 0.
// - Enable word 3 holds bits 15, 14, 11, 10, 6, 5, 2 and 1, read/write, reset 0.
// - An enable bit set lets its source interrupt, clear blocks it, and it holds until written or reset.
// The code gates src_pending with it; the flag status raises irq regardless.
// - Each source has a 3-bit priority level, 7 highest, reset to 4.
`timescale 1ns/1ps
`default_nettype none
`include "ifb_defs.vh"

module ifb_bank (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire [63:0] src_event,
    output reg [63:0] src_pending,
    output reg [191:0] src_prio,
    output reg irq
);

// ----------------------------------------
// Address phase capture
// ----------------------------------------
reg wr_pend_r;
reg [7:0] wr_idx_r;
wire [7:0] a_idx;
wire a_take;
wire [15:0] wdat;

assign a_idx = haddr[9:2];
assign a_take = hsel && hready && htrans[1];
assign wdat = hwdata[15:0];

// Write held for the data phase, reads answered from address phase
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_pend_r <= 1'b0;
        wr_idx_r <= 8'h00;
    end else begin
        wr_pend_r <= a_take && hwrite;
        wr_idx_r <= a_idx;
    end
end

// Write strobe for a given register index
function wstb;
    input [7:0] idx;
    begin
        wstb = wr_pend_r && (wr_idx_r == idx);
    end
endfunction

// ----------------------------------------
// Write strobes
// ----------------------------------------
wire wr_fl4;
wire wr_fl5;
wire wr_fl6;
wire wr_fl7;
wire wr_en0;
wire wr_en1;
wire wr_en2;
wire wr_en3;
wire wr_irqen;
wire wr_irqclr;

// One strobe per register, live in the write's data phase
assign wr_fl4 = wstb(`IFB_IDX_FLAGS4);
assign wr_fl5 = wstb(`IFB_IDX_FLAGS5);
assign wr_fl6 = wstb(`IFB_IDX_FLAGS6);
assign wr_fl7 = wstb(`IFB_IDX_FLAGS7);
assign wr_en0 = wstb(`IFB_IDX_EN0);
assign wr_en1 = wstb(`IFB_IDX_EN1);
assign wr_en2 = wstb(`IFB_IDX_EN2);
assign wr_en3 = wstb(`IFB_IDX_EN3);
assign wr_irqen = wstb(`IFB_IDX_IRQEN);
assign wr_irqclr = wstb(`IFB_IDX_IRQCLR);

// ----------------------------------------
// Flag and enable words
// ----------------------------------------
wire [15:0] fl4, fl5, fl6, fl7, en0, en1, en2, en3;
wire [63:0] flags_all;
wire [63:0] en_all;

// Flag words: peripheral events set bits, software writes load them directly
ifb_word #(.MASK(`IFB_MASK_FLAGS4)) u_fl4 (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_fl4),
    .wr_data(wdat),
    .hw_set(src_event[15:0]),
    .word_r(fl4)
);

ifb_word #(.MASK(`IFB_MASK_FLAGS5)) u_fl5 (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_fl5),
    .wr_data(wdat),
    .hw_set(src_event[31:16]),
    .word_r(fl5)
);

ifb_word #(.MASK(`IFB_MASK_FLAGS6)) u_fl6 (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_fl6),
    .wr_data(wdat),
    .hw_set(src_event[47:32]),
    .word_r(fl6)
);

ifb_word #(.MASK(`IFB_MASK_FLAGS7)) u_fl7 (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_fl7),
    .wr_data(wdat),
    .hw_set(src_event[63:48]),
    .word_r(fl7)
);

// Enable words: software only, no hardware set
ifb_word #(.MASK(`IFB_MASK_EN0)) u_en0 (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_en0),
    .wr_data(wdat),
    .hw_set(16'h0000),
    .word_r(en0)
);

ifb_word #(.MASK(`IFB_MASK_EN1)) u_en1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_en1),
    .wr_data(wdat),
    .hw_set(16'h0000),
    .word_r(en1)
);

ifb_word #(.MASK(`IFB_MASK_EN2)) u_en2 (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_en2),
    .wr_data(wdat),
    .hw_set(16'h0000),
    .word_r(en2)
);

ifb_word #(.MASK(`IFB_MASK_EN3)) u_en3 (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_en3),
    .wr_data(wdat),
    .hw_set(16'h0000),
    .word_r(en3)
);

assign flags_all = {fl7, fl6, fl5, fl4};
assign en_all = {en3, en2, en1, en0};

// ----------------------------------------
// Priority levels
// ----------------------------------------
wire [2:0] prio_rd;
wire [191:0] prio_flat;
wire prio_wr;

assign prio_wr = wr_pend_r && (wr_idx_r[7:6] == `IFB_IDX_PRIO_BASE >> 6);

ifb_prio u_prio (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(prio_wr),
    .wr_sel(wr_idx_r[5:0]),
    .wr_data(hwdata[2:0]),
    .rd_sel(a_idx[5:0]),
    .rd_data(prio_rd),
    .prio_flat(prio_flat)
);

// ----------------------------------------
// Pending and summary events
// ----------------------------------------
wire [63:0] pend_nxt;
reg any_flag_r;
reg any_pend_r;
reg [`IFB_STAT_W-1:0] stat_evt;

assign pend_nxt = flags_all & en_all;

// Status events on rising summary conditions
always @* begin
    stat_evt = {`IFB_STAT_W{1'b0}};
    stat_evt[`IFB_STAT_FLAG] = (|flags_all) & ~any_flag_r;
    stat_evt[`IFB_STAT_PEND] = (|pend_nxt) & ~any_pend_r;
end

// Summary levels of the previous cycle, for edge detection
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        any_flag_r <= 1'b0;
        any_pend_r <= 1'b0;
    end else begin
        any_flag_r <= |flags_all;
        any_pend_r <= |pend_nxt;
    end
end

// ----------------------------------------
// Sticky status, enable, write-one clear
// ----------------------------------------
reg [`IFB_STAT_W-1:0] stat_r;
reg [`IFB_STAT_W-1:0] irqen_r;
wire [`IFB_STAT_W-1:0] stat_clr;

assign stat_clr = wr_irqclr ? hwdata[`IFB_STAT_W-1:0] : {`IFB_STAT_W{1'b0}};

// Set wins over a clear in the same cycle
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        stat_r <= {`IFB_STAT_W{1'b0}};
        irqen_r <= {`IFB_STAT_W{1'b0}};
    end else begin
        stat_r <= (stat_r & ~stat_clr) | stat_evt;
        if (wr_irqen) begin
            irqen_r <= hwdata[`IFB_STAT_W-1:0];
        end
    end
end

// Registered outputs toward the CPU
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        src_pending <= 64'h0;
        src_prio <= {64{`IFB_RST_PRIO}};
        irq <= 1'b0;
    end else begin
        src_pending <= pend_nxt;
        src_prio <= prio_flat;
        irq <= |(stat_r & irqen_r);
    end
end

// ----------------------------------------
// Read mux
// ----------------------------------------
reg [15:0] rd_nxt;

always @* begin
    rd_nxt = 16'h0000;
    if (a_idx[7:6] == `IFB_IDX_PRIO_BASE >> 6) begin
        rd_nxt = {13'h0, prio_rd};
    end else begin
        case (a_idx)
            `IFB_IDX_FLAGS4: rd_nxt = fl4;
            `IFB_IDX_FLAGS5: rd_nxt = fl5;
            `IFB_IDX_FLAGS6: rd_nxt = fl6;
            `IFB_IDX_FLAGS7: rd_nxt = fl7;
            `IFB_IDX_EN0: rd_nxt = en0;
            `IFB_IDX_EN1: rd_nxt = en1;
            `IFB_IDX_EN2: rd_nxt = en2;
            `IFB_IDX_EN3: rd_nxt = en3;
            `IFB_IDX_STAT: rd_nxt = {14'h0, stat_r};
            `IFB_IDX_IRQEN: rd_nxt = {14'h0, irqen_r};
            default: rd_nxt = 16'h0000;
        endcase
    end
end

// Zero-wait answer, always OKAY
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata <= 32'h00000000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end else begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        if (a_take && !hwrite) begin
            hrdata <= {16'h0000, rd_nxt};
        end
    end
end

endmodule // ifb_bank
`default_nettype wire

/* File: testbench/ifb_src_model.sv */
// Peripheral event sources that drive the request lines
`timescale 1ns/1ps
`default_nettype none

module ifb_src_model (
    input wire logic hclk,
    output logic [63:0] src_event
);
    // Lines stay low until a peripheral reports
    initial src_event = 64'h0;

    // Event on the chosen lines, held for n cycles
    task automatic fire(input logic [63:0] m, input int n);
        src_event <= m;
        repeat (n) @(posedge hclk);
        src_event <= 64'h0;
    endtask
endmodule // ifb_src_model

`default_nettype wire

/* File: testbench/ifb_bank_checker.sv */
// Port assertions for the flag and enable bank
`timescale 1ns/1ps
`default_nettype none
`include "ifb_defs.vh"

module ifb_bank_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [63:0] src_event,
    input wire logic [63:0] src_pending,
    input wire logic [191:0] src_prio
);
    // ----
    // Transfer decode
    // ----
    wire logic taken = hsel & hready & htrans[1];
    wire logic wr_t = taken & hwrite;
    wire logic rd_t = taken & ~hwrite;
    wire logic [63:0] pmask = {`IFB_MASK_FLAGS7 & `IFB_MASK_EN3, `IFB_MASK_FLAGS6 & `IFB_MASK_EN2,
        `IFB_MASK_FLAGS5 & `IFB_MASK_EN1, `IFB_MASK_FLAGS4 & `IFB_MASK_EN0};
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    zero_wait_a: assert property (hreadyout) else $error("wait state");
    okay_resp_a: assert property (!hresp) else $error("error response");
    read_upper_a: assert property (hrdata[31:16] == 16'h0) else $error("upper");
    read_hold_a: assert property (!$past(rd_t) |-> $stable(hrdata))
        else $error("read data moved");
    pend_mask_a: assert property ((src_pending & ~pmask) == 64'h0)
        else $error("pending on absent bit");
    pend_fall_a: assert property (|($past(src_pending) & ~src_pending) |->
        $past(wr_t, 2) || $past(wr_t, 3) || $past(wr_t, 4)) else $error("pending lost");
    pend_rise_a: assert property (|(src_pending & ~$past(src_pending)) |->
        $past(|src_event, 2) || $past(wr_t, 3)) else $error("pending from nowhere");
    prio_write_a: assert property ($changed(src_prio) |->
        $past(wr_t, 2) || $past(wr_t, 3)) else $error("priority moved");
endmodule // ifb_bank_checker

bind ifb_bank ifb_bank_checker chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_event(src_event),
    .src_pending(src_pending), .src_prio(src_prio));

`default_nettype wire

/* File: testbench/irq_flag_enable_bank_bench.sv */
// Register, event and interrupt tests of the flag and enable bank
`timescale 1ns/1ps
`default_nettype none
`include "ifb_defs.vh"

module irq_flag_enable_bank_bench;
    // ----
    // Signals, tables and bus tasks
    // ----
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic [63:0] src_event;
    logic [63:0] src_pending;
    logic [191:0] src_prio;
    logic [15:0] masks [8] = '{`IFB_MASK_FLAGS4, `IFB_MASK_FLAGS5, `IFB_MASK_FLAGS6,
        `IFB_MASK_FLAGS7, `IFB_MASK_EN0, `IFB_MASK_EN1, `IFB_MASK_EN2, `IFB_MASK_EN3};
    logic [63:0] pm;
    int bad_count = 0;
    int n_checks = 0;

    always #25 hclk = ~hclk;

    ifb_bank dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .src_event(src_event), .src_pending(src_pending), .src_prio(src_prio), .irq(irq));
    ifb_src_model src (.hclk(hclk), .src_event(src_event));

    task automatic chk(input string nm, input logic [191:0] exp, input logic [191:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Single word transfer, address phase then data phase
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask

    task automatic settle;
        repeat (3) @(posedge hclk);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog against a hung bus
    initial begin
        repeat (5000) @(posedge hclk);
        bad_count++;
        end_of_test;
    end

    // Test sequence
    initial begin
        pm = {masks[3] & masks[7], masks[2] & masks[6], masks[1] & masks[5], masks[0] & masks[4]};
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        chk("prio_out", {64{3'h4}}, src_prio);
        rd("prio_rd", 32'h300, 32'h4);
        for (int i = 0; i < 8; i++) begin
            rd("reset", 32'h240 + 32'(i * 8), 32'h0);
            wr(32'h240 + 32'(i * 8), 32'hffffffff);
            rd("ones", 32'h240 + 32'(i * 8), {16'h0, masks[i]});
            wr(32'h240 + 32'(i * 8), 32'h0);
            rd("zeros", 32'h240 + 32'(i * 8), 32'h0);
        end
        wr(32'h2c8, 32'h3);
        wr(32'h2c4, 32'h1);
        src.fire({64{1'b1}}, 1);
        settle;
        chk("irq_flag", 1'b1, irq);
        chk("pend_off", 64'h0, src_pending);
        rd("status", 32'h2c0, 32'h1);
        for (int i = 0; i < 4; i++) begin
            rd("evt", 32'h240 + 32'(i * 8), {16'h0, masks[i]});
        end
        wr(32'h2c4, 32'h0);
        settle;
        chk("irq_mask", 1'b0, irq);
        wr(32'h2c8, 32'h3);
        rd("stat_clr", 32'h2c0, 32'h0);
        for (int i = 4; i < 8; i++) begin
            wr(32'h240 + 32'(i * 8), 32'hffff);
        end
        settle;
        chk("pend_on", pm, src_pending);
        rd("stat_pend", 32'h2c0, 32'h2);
        wr(32'h2c4, 32'h2);
        settle;
        chk("irq_pend", 1'b1, irq);
        wr(32'h240, 32'h0);
        settle;
        chk("pend_clr", {pm[63:16], 16'h0}, src_pending);
        wr(32'h268, 32'h0);
        settle;
        chk("pend_dis", {pm[63:32], 32'h0}, src_pending);
        fork
            src.fire(64'h0020_0000_0000_0000, 8);
            wr(32'h258, 32'h0);
        join
        rd("evt_wins", 32'h258, 32'h20);
        wr(32'h314, 32'h7);
        rd("prio5", 32'h314, 32'h7);
        chk("prio5_out", 3'h7, src_prio[17:15]);
        wr(32'h200, 32'hffff);
        rd("unmapped", 32'h200, 32'h0);
        // Reset in mid-run returns words to zero and levels to 4
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        chk("prio_rst", {64{3'h4}}, src_prio);
        chk("pend_rst", 64'h0, src_pending);
        chk("irq_rst", 1'b0, irq);
        rd("fl7_rst", 32'h258, 32'h0);
        rd("en3_rst", 32'h278, 32'h0);
        end_of_test;
    end
endmodule // irq_flag_enable_bank_bench

`default_nettype wire
